// *** sfs_pkg.sv ***
// Operation
// - Frame allocation opcode is FA plus two zero bits; literal bit 0 reads zero.
// - Allocation pushes frame pointer, stack pointer plus 2, copy, add literal.
// - Frame size literal is an unsigned 14-bit byte count, 0 to 16382.
// - Size select 0 picks word width, 1 picks byte width.
// - Target 0 writes working register zero, 1 writes the file register.
// - Default working register is working register zero.
// - File address is the 13-bit location field, 0 to 8191.
// - Byte shift moves bits 7:1 to 6:0, bit 7 cleared.
// - Word shift moves bits 15:1 to 14:0, bit 15 cleared.
// - Source bit 0 goes to the shifted-out flag.
// - Shift updates msb, null and shifted-out flags only.
// - Shift completes in one execute cycle.
package sfs_pkg;
  localparam int          SFS_AW         = 8;
  localparam int          SFS_MEM_WORDS  = 4096;
  localparam logic [7:0]  OFF_INSTR      = 8'h00;
  localparam logic [7:0]  OFF_WZERO      = 8'h04;
  localparam logic [7:0]  OFF_FRAME      = 8'h08;
  localparam logic [7:0]  OFF_STACK      = 8'h0C;
  localparam logic [7:0]  OFF_STATUS     = 8'h10;
  localparam logic [7:0]  OFF_CORE       = 8'h14;
  localparam logic [7:0]  OFF_CFG        = 8'h18;
  localparam logic [7:0]  OFF_MADDR      = 8'h1C;
  localparam logic [7:0]  OFF_MDATA      = 8'h20;
  localparam logic [7:0]  OFF_EXSTAT     = 8'h24;
  localparam logic [7:0]  OP_ALLOC_HI    = 8'hFA;
  localparam logic [7:0]  OP_SHIFT_HI    = 8'hD5;
  localparam int          SR_C_BIT       = 0;
  localparam int          SR_Z_BIT       = 1;
  localparam int          SR_N_BIT       = 3;
  localparam logic [15:0] SR_SHIFT_MASK  = 16'h000B;
  localparam int          CORE_FRAME_BIT = 2;
  localparam int          EX_ILLEGAL_BIT = 0;
  localparam logic [15:0] STACK_STEP     = 16'h0002;
  localparam logic [15:0] REG16_RESET    = 16'h0000;
  localparam logic [23:0] INSTR_RESET    = 24'h00_0000;
  localparam logic [1:0]  RESP_OKAY      = 2'b00;
  localparam logic [1:0]  RESP_SLVERR    = 2'b10;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_RESP = 2'b11
  } sfs_fsm_type;

  typedef struct packed {
    logic        is_alloc;
    logic        is_shift;
    logic [15:0] lit;
    logic        byte_sel;
    logic        to_file;
    logic [12:0] faddr;
  } sfs_dec_type;

  typedef struct packed {
    sfs_fsm_type        st;
    logic               aw_got;
    logic               w_got;
    logic [SFS_AW-1:0]  awaddr;
    logic [31:0]        wdata;
    logic [3:0]         wstrb;
    logic [1:0]         bresp;
    logic               rvalid;
    logic [31:0]        rdata;
    logic [1:0]         rresp;
    logic [23:0]        instr;
    logic [15:0]        wzero;
    logic [15:0]        fp;
    logic [15:0]        sp;
    logic [15:0]        sr;
    logic [15:0]        core;
    logic               cfg_active;
    logic [12:0]        maddr;
    logic               illegal;
  } sfs_state_type;
endpackage

// *** sfs_exec_top.sv ***
`timescale 1ns/1ps
module sfs_exec_top
  import sfs_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic [SFS_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [SFS_AW-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  sfs_state_type s_ff;
  sfs_state_type nxt_s;
  sfs_dec_type   dec;
  logic [15:0]   mem [0:SFS_MEM_WORDS-1];
  logic          mem_we;
  logic [11:0]   mem_wa;
  logic [15:0]   mem_wd;
  logic [15:0]   src_word;
  logic [15:0]   src;
  logic [15:0]   res;
  logic [15:0]   sp_inc;
  logic [31:0]   wval;

  function automatic sfs_dec_type decode(input logic [23:0] op);
    sfs_dec_type d;
    d.is_alloc = (op[23:16] == OP_ALLOC_HI) && (op[15:14] == 2'b00);
    d.is_shift = (op[23:16] == OP_SHIFT_HI) && !op[15];
    d.lit      = {2'b00, op[13:1], 1'b0};
    d.byte_sel = op[14];
    d.to_file  = op[13];
    d.faddr    = op[12:0];
    return d;
  endfunction

  // Register writes honour byte lanes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0]  stb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (stb[i]) begin
        m[8*i +: 8] = dat[8*i +: 8];
      end
    end
    return m;
  endfunction

  function automatic logic mapped(input logic [SFS_AW-1:0] a);
    return (a <= OFF_EXSTAT) && (a[1:0] == 2'b00);
  endfunction

  assign dec      = decode(s_ff.instr);
  assign src_word = mem[dec.faddr[12:1]];
  // Byte operand is the addressed half, zero extended
  assign src = dec.byte_sel ? (dec.faddr[0] ? {8'h00, src_word[15:8]}
                                            : {8'h00, src_word[7:0]})
                            : src_word;
  assign res = dec.byte_sel ? {9'h000, src[7:1]}
                            : {1'b0, src[15:1]};
  assign sp_inc = s_ff.sp + STACK_STEP;

  assign s_axi_awready = (s_ff.st == ST_IDLE) && !s_ff.aw_got;
  assign s_axi_wready  = (s_ff.st == ST_IDLE) && !s_ff.w_got;
  assign s_axi_bvalid  = (s_ff.st == ST_RESP);
  assign s_axi_bresp   = s_ff.bresp;
  assign s_axi_arready = !s_ff.rvalid;
  assign s_axi_rvalid  = s_ff.rvalid;
  assign s_axi_rdata   = s_ff.rdata;
  assign s_axi_rresp   = s_ff.rresp;

  always_comb begin
    nxt_s  = s_ff;
    mem_we = 1'b0;
    mem_wa = '0;
    mem_wd = '0;
    wval   = '0;
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_s.aw_got = 1'b1;
      nxt_s.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_s.w_got = 1'b1;
      nxt_s.wdata = s_axi_wdata;
      nxt_s.wstrb = s_axi_wstrb;
    end
    unique case (s_ff.st)
      ST_IDLE: begin
        if (s_ff.aw_got && s_ff.w_got) begin
          nxt_s.aw_got = 1'b0;
          nxt_s.w_got  = 1'b0;
          nxt_s.bresp  = RESP_OKAY;
          nxt_s.st     = ST_RESP;
          unique case (s_ff.awaddr)
            OFF_INSTR: begin
              wval = merge({8'h00, s_ff.instr}, s_ff.wdata, s_ff.wstrb);
              nxt_s.instr = wval[23:0];
              nxt_s.st    = ST_EXEC;
            end
            OFF_WZERO: begin
              wval = merge({16'h0000, s_ff.wzero}, s_ff.wdata, s_ff.wstrb);
              nxt_s.wzero = wval[15:0];
            end
            OFF_FRAME: begin
              wval = merge({16'h0000, s_ff.fp}, s_ff.wdata, s_ff.wstrb);
              nxt_s.fp = wval[15:0];
            end
            OFF_STACK: begin
              wval = merge({16'h0000, s_ff.sp}, s_ff.wdata, s_ff.wstrb);
              nxt_s.sp = wval[15:0];
            end
            OFF_STATUS: begin
              wval = merge({16'h0000, s_ff.sr}, s_ff.wdata, s_ff.wstrb);
              nxt_s.sr = wval[15:0];
            end
            OFF_CORE: begin
              wval = merge({16'h0000, s_ff.core}, s_ff.wdata, s_ff.wstrb);
              nxt_s.core = wval[15:0];
            end
            OFF_CFG: begin
              if (s_ff.wstrb[0]) begin
                nxt_s.cfg_active = s_ff.wdata[0];
              end
            end
            OFF_MADDR: begin
              wval = merge({19'h0_0000, s_ff.maddr}, s_ff.wdata,
                           s_ff.wstrb);
              nxt_s.maddr = wval[12:0];
            end
            OFF_MDATA: begin
              wval   = merge({16'h0000, mem[s_ff.maddr[12:1]]},
                             s_ff.wdata, s_ff.wstrb);
              mem_we = 1'b1;
              mem_wa = s_ff.maddr[12:1];
              mem_wd = wval[15:0];
            end
            OFF_EXSTAT: begin
              // Write one to clear
              if (s_ff.wstrb[0] && s_ff.wdata[EX_ILLEGAL_BIT]) begin
                nxt_s.illegal = 1'b0;
              end
            end
            default: nxt_s.bresp = RESP_SLVERR;
          endcase
        end
      end
      ST_EXEC: begin
        nxt_s.st = ST_RESP;
        if (dec.is_alloc) begin
          mem_we   = 1'b1;
          mem_wa   = s_ff.sp[12:1];
          mem_wd   = s_ff.fp;
          nxt_s.fp = sp_inc;
          nxt_s.sp = sp_inc + dec.lit;
          if (s_ff.cfg_active) begin
            nxt_s.core[CORE_FRAME_BIT] = 1'b1;
          end
        end else if (dec.is_shift) begin
          nxt_s.sr[SR_C_BIT] = src[0];
          nxt_s.sr[SR_N_BIT] = dec.byte_sel ? res[7] : res[15];
          nxt_s.sr[SR_Z_BIT] = dec.byte_sel ? (res[7:0] == 8'h00)
                                            : (res == 16'h0000);
          if (!dec.to_file) begin
            // Byte result lands in the low half only
            nxt_s.wzero = dec.byte_sel ? {s_ff.wzero[15:8], res[7:0]}
                                       : res;
          end else begin
            mem_we = 1'b1;
            mem_wa = dec.faddr[12:1];
            if (!dec.byte_sel) begin
              mem_wd = res;
            end else if (dec.faddr[0]) begin
              mem_wd = {res[7:0], src_word[7:0]};
            end else begin
              mem_wd = {src_word[15:8], res[7:0]};
            end
          end
        end else begin
          nxt_s.illegal = 1'b1;
        end
      end
      ST_RESP: begin
        if (s_axi_bready) begin
          nxt_s.st = ST_IDLE;
        end
      end
      default: nxt_s.st = ST_IDLE;
    endcase
    if (s_ff.rvalid && s_axi_rready) begin
      nxt_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_s.rvalid = 1'b1;
      nxt_s.rresp  = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_axi_araddr)
        OFF_INSTR:  nxt_s.rdata = {8'h00, s_ff.instr};
        OFF_WZERO:  nxt_s.rdata = {16'h0000, s_ff.wzero};
        OFF_FRAME:  nxt_s.rdata = {16'h0000, s_ff.fp};
        OFF_STACK:  nxt_s.rdata = {16'h0000, s_ff.sp};
        OFF_STATUS: nxt_s.rdata = {16'h0000, s_ff.sr};
        OFF_CORE:   nxt_s.rdata = {16'h0000, s_ff.core};
        OFF_CFG:    nxt_s.rdata = {31'h0000_0000, s_ff.cfg_active};
        OFF_MADDR:  nxt_s.rdata = {19'h0_0000, s_ff.maddr};
        OFF_MDATA:  nxt_s.rdata = {16'h0000, mem[s_ff.maddr[12:1]]};
        OFF_EXSTAT: nxt_s.rdata = {30'h0000_0000,
                                   (s_ff.st != ST_IDLE), s_ff.illegal};
        default:    nxt_s.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_ff        <= '0;
      s_ff.st     <= ST_IDLE;
      s_ff.instr  <= INSTR_RESET;
      s_ff.wzero  <= REG16_RESET;
      s_ff.fp     <= REG16_RESET;
      s_ff.sp     <= REG16_RESET;
      s_ff.sr     <= REG16_RESET;
      s_ff.core   <= REG16_RESET;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Data memory keeps no reset; it models plain RAM
  always_ff @(posedge clk_sys) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  a_exec_one_cycle: assert property (
    s_ff.st == ST_EXEC |=> s_ff.st == ST_RESP && $past(s_ff.st) == ST_EXEC)
    else $error("execute did not finish in one cycle");

  a_instr_starts_exec: assert property (
    s_ff.st == ST_IDLE && s_ff.aw_got && s_ff.w_got
    && s_ff.awaddr == OFF_INSTR |=> s_ff.st == ST_EXEC)
    else $error("opcode write did not start execution");

  a_alloc_frame_ptr: assert property (
    s_ff.st == ST_EXEC && dec.is_alloc
    |=> s_ff.fp == 16'($past(s_ff.sp) + STACK_STEP))
    else $error("frame pointer not loaded with stack pointer plus two");

  a_alloc_stack_add: assert property (
    s_ff.st == ST_EXEC && dec.is_alloc
    |=> s_ff.sp == 16'($past(s_ff.sp) + STACK_STEP + $past(dec.lit)))
    else $error("stack pointer not advanced by frame size");

  a_alloc_push_top: assert property (
    s_ff.st == ST_EXEC && dec.is_alloc
    |=> mem[$past(s_ff.sp[12:1])] == $past(s_ff.fp))
    else $error("old frame pointer not pushed");

  a_alloc_active_set: assert property (
    s_ff.st == ST_EXEC && dec.is_alloc
    |=> s_ff.core[CORE_FRAME_BIT] == ($past(s_ff.cfg_active)
        || $past(s_ff.core[CORE_FRAME_BIT])) && $stable(s_ff.sr))
    else $error("frame active bit or status wrong after allocation");

  a_illegal_no_change: assert property (
    s_ff.st == ST_EXEC && !dec.is_alloc && !dec.is_shift
    |=> s_ff.illegal && $stable(s_ff.sp) && $stable(s_ff.fp)
        && $stable(s_ff.sr) && $stable(s_ff.wzero))
    else $error("unknown opcode changed state or was not flagged");

  a_shift_carry_out: assert property (
    s_ff.st == ST_EXEC && dec.is_shift
    |=> s_ff.sr[SR_C_BIT] == $past(src[0]) && !s_ff.sr[SR_N_BIT])
    else $error("shifted out bit or msb flag wrong");

  a_shift_other_bits: assert property (
    s_ff.st == ST_EXEC && dec.is_shift
    |=> (s_ff.sr & ~SR_SHIFT_MASK) == ($past(s_ff.sr) & ~SR_SHIFT_MASK))
    else $error("shift disturbed unrelated status bits");

  a_shift_ptrs_kept: assert property (
    s_ff.st == ST_EXEC && dec.is_shift
    |=> $stable(s_ff.sp) && $stable(s_ff.fp) && $stable(s_ff.core))
    else $error("shift disturbed pointers or core control");

  a_shift_zero_flag: assert property (
    s_ff.st == ST_EXEC && dec.is_shift
    |=> s_ff.sr[SR_Z_BIT] == ($past(dec.byte_sel)
        ? ($past(src[7:1]) == 7'h00)
        : ($past(src_word[15:1]) == 15'h0000)))
    else $error("null result flag wrong after shift");

  a_shift_word_wzero: assert property (
    s_ff.st == ST_EXEC && dec.is_shift && !dec.to_file && !dec.byte_sel
    |=> s_ff.wzero == ($past(src) >> 1)
        && s_ff.sr[SR_Z_BIT] == ($past(src[15:1]) == 15'h0000))
    else $error("word shift into working register zero wrong");

  a_shift_byte_wzero: assert property (
    s_ff.st == ST_EXEC && dec.is_shift && !dec.to_file && dec.byte_sel
    |=> s_ff.wzero == {$past(s_ff.wzero[15:8]), 1'b0, $past(src[7:1])})
    else $error("byte shift into working register zero wrong");

  a_wzero_keeps_file: assert property (
    s_ff.st == ST_EXEC && dec.is_shift && !dec.to_file
    |=> mem[$past(dec.faddr[12:1])] == $past(src_word))
    else $error("working register target also wrote the file register");

  // File results are checked against the raw word, not the shifter output
  a_shift_word_file: assert property (
    s_ff.st == ST_EXEC && dec.is_shift && dec.to_file && !dec.byte_sel
    |=> mem[$past(dec.faddr[12:1])] == {1'b0, $past(src_word[15:1])})
    else $error("word shift into file register wrong");

  a_shift_byte_file: assert property (
    s_ff.st == ST_EXEC && dec.is_shift && dec.to_file && dec.byte_sel
    |=> mem[$past(dec.faddr[12:1])] == ($past(dec.faddr[0])
        ? {1'b0, $past(src[7:1]), $past(src_word[7:0])}
        : {$past(src_word[15:8]), 1'b0, $past(src[7:1])}))
    else $error("byte shift into file register wrong");

  a_file_keeps_wzero: assert property (
    s_ff.st == ST_EXEC && dec.is_shift && dec.to_file
    |=> $stable(s_ff.wzero))
    else $error("file register target also wrote working register zero");

endmodule

// *** tb.sv ***
`timescale 1ns/1ps
module tb;
  import sfs_pkg::*;
  logic              clk_sys;
  logic              rst_n;
  logic [SFS_AW-1:0] awaddr;
  logic              awvalid;
  logic              awready;
  logic [31:0]       wdata;
  logic [3:0]        wstrb;
  logic              wvalid;
  logic              wready;
  logic [1:0]        bresp;
  logic              bvalid;
  logic              bready;
  logic [SFS_AW-1:0] araddr;
  logic              arvalid;
  logic              arready;
  logic [31:0]       rdata;
  logic [1:0]        rresp;
  logic              rvalid;
  logic              rready;
  int                mismatches;
  int                n_checks;
  logic [31:0]       rd;
  logic [1:0]        rs;
  // maddr, mem, wzero, status, opcode low, then expected mem, wzero, status
  logic [15:0]       sh [6][8] = '{
    '{16'h0600, 16'h55FF, 16'h1234, 16'hFFF4, 16'h6600, 16'h557F, 16'h1234,
      16'hFFF5},
    '{16'h0600, 16'h55FF, 16'h0000, 16'h0008, 16'h0600, 16'h55FF, 16'h2AFF,
      16'h0001},
    '{16'h1FFF, 16'h0155, 16'hABCD, 16'h0000, 16'h5FFF, 16'h0155, 16'hAB00,
      16'h0003},
    '{16'h0002, 16'h8000, 16'h5555, 16'h0003, 16'h2002, 16'h4000, 16'h5555,
      16'h0000},
    '{16'h0603, 16'h02FF, 16'h5555, 16'h0002, 16'h6603, 16'h01FF, 16'h5555,
      16'h0000},
    '{16'h0010, 16'h0001, 16'hFFFF, 16'h0000, 16'h0010, 16'h0001, 16'h0000,
      16'h0003}};

  sfs_exec_top sfs_exec_top_inst (
    .clk_sys       (clk_sys),
    .rst_n         (rst_n),
    .s_axi_awaddr  (awaddr),
    .s_axi_awvalid (awvalid),
    .s_axi_awready (awready),
    .s_axi_wdata   (wdata),
    .s_axi_wstrb   (wstrb),
    .s_axi_wvalid  (wvalid),
    .s_axi_wready  (wready),
    .s_axi_bresp   (bresp),
    .s_axi_bvalid  (bvalid),
    .s_axi_bready  (bready),
    .s_axi_araddr  (araddr),
    .s_axi_arvalid (arvalid),
    .s_axi_arready (arready),
    .s_axi_rdata   (rdata),
    .s_axi_rresp   (rresp),
    .s_axi_rvalid  (rvalid),
    .s_axi_rready  (rready)
  );

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic hung();
    mismatches++;
    $display("unexpected handshake: expected answer seen none");
    close_out();
  endtask

  // Ready sampled at the falling edge: inputs only move at rising edges
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic ta;
    logic tw;
    logic done;
    done = 1'b0;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 50 && !done; n++) begin
      @(negedge clk_sys);
      ta = awvalid && (awready === 1'b1);
      tw = wvalid && (wready === 1'b1);
      done = (bvalid === 1'b1);
      r = bresp;
      @(posedge clk_sys);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (done) bready <= 1'b0;
    end
    if (!done) hung();
  endtask

  task automatic rdt(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    logic ta;
    logic done;
    done = 1'b0;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 50 && !done; n++) begin
      @(negedge clk_sys);
      ta = arvalid && (arready === 1'b1);
      done = (rvalid === 1'b1);
      d = rdata;
      r = rresp;
      @(posedge clk_sys);
      if (ta) arvalid <= 1'b0;
      if (done) rready <= 1'b0;
    end
    if (!done) hung();
  endtask

  task automatic w(input logic [7:0] a, input logic [31:0] d);
    wr(a, d, rs);
    chk("bresp", {30'h0000_0000, RESP_OKAY}, {30'h0000_0000, rs});
  endtask

  task automatic rc(input string nm, input logic [7:0] a,
                    input logic [31:0] e);
    rdt(a, rd, rs);
    chk(nm, e, rd);
    chk("rresp", {30'h0000_0000, RESP_OKAY}, {30'h0000_0000, rs});
  endtask

  initial begin
    rst_n = 1'b0;
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0000_0000;
    wstrb = 4'hF;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
    mismatches = 0;
    n_checks = 0;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    rc("status", OFF_STATUS, 32'h0000_0000);
    rdt(8'h28, rd, rs);
    chk("rresp", {30'h0000_0000, RESP_SLVERR}, {30'h0000_0000, rs});
    chk("rdata", 32'h0000_0000, rd);
    wr(8'h02, 32'h0000_FFFF, rs);
    chk("bresp", {30'h0000_0000, RESP_SLVERR}, {30'h0000_0000, rs});
    $display("test access done");
    w(OFF_CFG, 32'h0000_0001);
    w(OFF_FRAME, 32'h0000_1000);
    w(OFF_STACK, 32'h0000_0800);
    w(OFF_STATUS, 32'h0000_00F0);
    w(OFF_CORE, 32'h0000_0000);
    w(OFF_INSTR, 32'h00FA_00A0);
    rc("frame", OFF_FRAME, 32'h0000_0802);
    rc("stack", OFF_STACK, 32'h0000_08A2);
    rc("core", OFF_CORE, 32'h0000_0004);
    rc("status", OFF_STATUS, 32'h0000_00F0);
    w(OFF_MADDR, 32'h0000_0800);
    rc("pushed", OFF_MDATA, 32'h0000_1000);
    // Largest size, literal bit 0 set to show it is ignored
    w(OFF_CFG, 32'h0000_0000);
    w(OFF_CORE, 32'h0000_0000);
    w(OFF_INSTR, 32'h00FA_3FFF);
    rc("stack", OFF_STACK, 32'h0000_48A2);
    rc("frame", OFF_FRAME, 32'h0000_08A4);
    rc("core", OFF_CORE, 32'h0000_0000);
    w(OFF_MADDR, 32'h0000_08A2);
    rc("pushed", OFF_MDATA, 32'h0000_0802);
    w(OFF_INSTR, 32'h00FA_4000);
    rc("exstat", OFF_EXSTAT, 32'h0000_0001);
    rc("stack", OFF_STACK, 32'h0000_48A2);
    w(OFF_EXSTAT, 32'h0000_0001);
    rc("exstat", OFF_EXSTAT, 32'h0000_0000);
    $display("test allocate done");
    for (int i = 0; i < 6; i++) begin
      w(OFF_MADDR, {16'h0000, sh[i][0]});
      w(OFF_MDATA, {16'h0000, sh[i][1]});
      w(OFF_WZERO, {16'h0000, sh[i][2]});
      w(OFF_STATUS, {16'h0000, sh[i][3]});
      w(OFF_INSTR, {8'h00, OP_SHIFT_HI, sh[i][4]});
      rc("file", OFF_MDATA, {16'h0000, sh[i][5]});
      rc("wzero", OFF_WZERO, {16'h0000, sh[i][6]});
      rc("status", OFF_STATUS, {16'h0000, sh[i][7]});
    end
    // Only byte lane 1 may land
    wstrb <= 4'h2;
    w(OFF_WZERO, 32'h0000_BBAA);
    wstrb <= 4'hF;
    rc("lanes", OFF_WZERO, 32'h0000_BB00);
    $display("test shift done");
    close_out();
  end
endmodule
